//--- logic/embc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

`include "embc_map.svh"

module embc_ctrl
   import embc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Core access request
   input wire logic req_i,
   input wire embc_req_t req_dat_i,
   input wire embc_ws_t wait_state_config_i,
   input wire logic power_down_i,
   output logic busy_o,
   output logic ack_o,
   output logic illegal_addr_o,
   // General-purpose use of the shared qualifier pin
   input wire logic port_c_bit0_sel_i,
   input wire logic port_c_bit0_i,
   input wire logic port_c_bit0_oe_i,
   // Device pins
   input wire logic ready_i,
   input wire logic emulation_output_disable_n_i,
   input wire logic external_if_enable_i,
   output logic [2:0] sync_o,
   output embc_pins_t pins_o,
   output embc_pins_t pins_oe_o
);

   typedef enum logic [1:0] {ST_IDLE, ST_ACT, ST_WAIT} embc_state_t;

   logic [2:0] sync_in;
   logic [2:0] sync1_d;
   logic [2:0] sync1_q;
   logic [2:0] sync2_d;
   logic [2:0] sync2_q;
   logic ready_s;
   logic emu_n_s;
   logic ext_en_s;
   embc_state_t state_d;
   embc_state_t state_q;
   embc_space_t space_d;
   embc_space_t space_q;
   logic write_d;
   logic write_q;
   logic [`EMBC_WS_W-1:0] cnt_d;
   logic [`EMBC_WS_W-1:0] cnt_q;
   logic ack_d;
   logic ack_q;
   logic ill_d;
   logic ill_q;
   logic take;
   logic active_d;
   logic [`EMBC_WS_W-1:0] ws_sel;
   embc_pins_t pins_d;
   embc_pins_t pins_q;
   embc_pins_t oe_d;
   embc_pins_t oe_q;

   // Every pin input is asynchronous to the core clock
   assign sync_in = {external_if_enable_i, emulation_output_disable_n_i, ready_i};

   always_comb
   begin
      sync1_d = sync_in;
      sync2_d = sync1_q;
   end

   // Two-stage synchronisers; only the second stage is read
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sync1_q <= `EMBC_SYNC_RST;
         sync2_q <= `EMBC_SYNC_RST;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   assign ready_s = sync2_q[0];
   assign emu_n_s = sync2_q[1];
   assign ext_en_s = sync2_q[2];
   assign sync_o = sync2_q;

   // Wait-state count of the requested space
   always_comb
   begin
      case (req_dat_i.space)
         SP_PROG: ws_sel = wait_state_config_i.prog;
         SP_DATA: ws_sel = wait_state_config_i.data;
         SP_IO: ws_sel = wait_state_config_i.io;
         default: ws_sel = wait_state_config_i.io;
      endcase
   end

   // Requests are refused while busy or powered down
   assign take = req_i && (state_q == ST_IDLE) && !power_down_i;
   assign busy_o = (state_q != ST_IDLE) || power_down_i;

   // Access sequencer
   always_comb
   begin
      state_d = state_q;
      space_d = space_q;
      write_d = write_q;
      cnt_d = cnt_q;
      ack_d = 1'b0;
      ill_d = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (take && !ext_en_s)
            begin
               ill_d = 1'b1;
            end
            else if (take)
            begin
               state_d = ST_ACT;
               space_d = req_dat_i.space;
               write_d = req_dat_i.write;
               cnt_d = ws_sel;
            end
         end
         ST_ACT:
         begin
            // Zero wait states: ready is never looked at
            if (cnt_q == '0)
            begin
               state_d = ST_IDLE;
               ack_d = 1'b1;
            end
            else
            begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT:
         begin
            if (cnt_q > `EMBC_WS_W'(`EMBC_RDY_RETRY))
            begin
               cnt_d = cnt_q - `EMBC_WS_W'(1);
            end
            // Last software wait: sample ready, stay a cycle if low
            else if (ready_s)
            begin
               state_d = ST_IDLE;
               ack_d = 1'b1;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_q <= ST_IDLE;
         space_q <= SP_PROG;
         write_q <= 1'b0;
         cnt_q <= '0;
         ack_q <= 1'b0;
         ill_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         space_q <= space_d;
         write_q <= write_d;
         cnt_q <= cnt_d;
         ack_q <= ack_d;
         ill_q <= ill_d;
      end
   end

   assign ack_o = ack_q;
   assign illegal_addr_o = ill_q;

   // Pin levels follow the next state so they change with the access edge
   always_comb
   begin
      active_d = (state_d != ST_IDLE);
      pins_d.prog_sel_n = !(active_d && space_d == SP_PROG);
      pins_d.data_sel_n = !(active_d && space_d == SP_DATA);
      pins_d.io_sel_n = !(active_d && space_d == SP_IO);
      pins_d.rw_n = !(active_d && write_d);
      pins_d.rd_n = !(active_d && !write_d);
      pins_d.we_n = !(active_d && write_d);
      pins_d.bus_cycle_strobe_n_n = !active_d;
      // The shared pin carries either the inverted qualifier or a port bit
      if (port_c_bit0_sel_i)
      begin
         pins_d.wr_rd = port_c_bit0_i;
      end
      else
      begin
         pins_d.wr_rd = active_d && write_d;
      end
   end

   // Output enables; reset forces them all low, so every pin floats
   always_comb
   begin
      oe_d.prog_sel_n = emu_n_s && !power_down_i;
      oe_d.data_sel_n = emu_n_s && !power_down_i;
      oe_d.io_sel_n = emu_n_s && !power_down_i;
      oe_d.rw_n = emu_n_s && !power_down_i;
      oe_d.rd_n = emu_n_s;
      oe_d.we_n = emu_n_s;
      oe_d.bus_cycle_strobe_n_n = emu_n_s && !power_down_i;
      oe_d.wr_rd = emu_n_s && (port_c_bit0_sel_i ? port_c_bit0_oe_i : !power_down_i);
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pins_q <= '{prog_sel_n: `EMBC_SEL_IDLE, data_sel_n: `EMBC_SEL_IDLE,
                     io_sel_n: `EMBC_SEL_IDLE, rw_n: `EMBC_SEL_IDLE,
                     wr_rd: `EMBC_WR_RD_IDLE, rd_n: `EMBC_SEL_IDLE,
                     we_n: `EMBC_SEL_IDLE, bus_cycle_strobe_n_n: `EMBC_SEL_IDLE};
         oe_q <= '0;
      end
      else
      begin
         pins_q <= pins_d;
         oe_q <= oe_d;
      end
   end

   assign pins_o = pins_q;
   assign pins_oe_o = oe_q;

   // Checks on the pin behaviour
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_wait_last_low;
      (state_q == ST_WAIT) && (cnt_q == `EMBC_WS_W'(1)) && !ready_s;
   endsequence

   sequence s_take_zero_ws;
      take && ext_en_s && (ws_sel == '0);
   endsequence

   a_sel_one_hot: assert property
      ($onehot0(~{pins_o.prog_sel_n, pins_o.data_sel_n, pins_o.io_sel_n}))
      else $error("more than one space select low");

   a_sel_in_bus_cycle_strobe_n: assert property
      (!(pins_o.prog_sel_n && pins_o.data_sel_n && pins_o.io_sel_n)
       |-> !pins_o.bus_cycle_strobe_n_n)
      else $error("space select low without bus-cycle strobe");

   a_rw_write_only: assert property
      (!pins_o.rw_n |-> (!pins_o.we_n && pins_o.rd_n && !pins_o.bus_cycle_strobe_n_n))
      else $error("qualifier low outside a write");

   a_inv_qualifier: assert property
      (!port_c_bit0_sel_i ##1 1'b1 |-> pins_o.wr_rd == !pins_o.rw_n)
      else $error("inverted qualifier does not mirror qualifier");

   a_read_strobe: assert property
      (take && ext_en_s && !req_dat_i.write |=> !pins_o.rd_n && pins_o.we_n)
      else $error("read strobe missing on external read");

   a_emu_float: assert property
      (!emu_n_s |=> (pins_oe_o == '0))
      else $error("output driven while emulation disable low");

   a_pd_float: assert property
      (power_down_i |=> !pins_oe_o.bus_cycle_strobe_n_n && !pins_oe_o.rw_n && !pins_oe_o.prog_sel_n)
      else $error("strobe driven in power down");

   a_ready_retry: assert property
      (s_wait_last_low |=> (state_q == ST_WAIT) && !pins_o.bus_cycle_strobe_n_n && !ack_o)
      else $error("access ended with ready low");

   a_zero_ws_len: assert property
      (s_take_zero_ws |=> !pins_o.bus_cycle_strobe_n_n ##1 pins_o.bus_cycle_strobe_n_n && ack_o)
      else $error("zero wait-state access not one cycle");

   // The first cycle after the take edge is the launch itself, so stability
   // is only asked of the cycles that follow it
   a_ws_stable: assert property
      (take && ext_en_s && (ws_sel == `EMBC_WS_W'(2)) |=>
       !pins_o.bus_cycle_strobe_n_n ##1 (!pins_o.bus_cycle_strobe_n_n && $stable(pins_o))[*2])
      else $error("strobes not stable through wait states");

   a_illegal_flag: assert property
      (take && !ext_en_s |=> illegal_addr_o && pins_o.bus_cycle_strobe_n_n)
      else $error("disabled interface did not flag access");

endmodule

`default_nettype wire

//--- logic/embc_map.svh
// Overview of operation
// - Space selects idle high, low during access
// - Space selects float in reset, powerdown, emulation
// - Direction qualifier high, low only on writes
// - Direction qualifier floats in powerdown and emulation
// - Inverted qualifier high only during writes
// - Read strobe low on every external read
// - Read strobe floats while emulation disable low
// - Write strobe low on every external write
// - Bus-cycle strobe idle high, low per cycle
// - Bus-cycle strobe marks every off-chip access
// - Bus-cycle strobe floats in powerdown and emulation
// - Ready low: wait a cycle, sample again
// - Ready sampled only with software wait states
// - Emulation disable low floats every output
// - Interface disabled: flag illegal external access
`ifndef EMBC_MAP_SVH
`define EMBC_MAP_SVH

// Width of one per-space software wait-state count
`define EMBC_WS_W 3

// Synchroniser reset values, bit order {if_enable, emu_disable_n, ready}
`define EMBC_SYNC_RST 3'h1

// Idle pin levels: strobes and qualifier high, inverted qualifier low
`define EMBC_SEL_IDLE 1'h1
`define EMBC_WR_RD_IDLE 1'h0

// Wait count at which the countdown stops and ready is sampled each cycle
`define EMBC_RDY_RETRY 1

`endif

//--- logic/embc_pkg.sv
`default_nettype none

`include "embc_map.svh"

package embc_pkg;

   // External address spaces
   typedef enum logic [1:0] {SP_PROG, SP_DATA, SP_IO} embc_space_t;

   // One access request from the core
   typedef struct packed {
      embc_space_t space;
      logic write;
   } embc_req_t;

   // Software wait states per space
   typedef struct packed {
      logic [`EMBC_WS_W-1:0] prog;
      logic [`EMBC_WS_W-1:0] data;
      logic [`EMBC_WS_W-1:0] io;
   } embc_ws_t;

   // Control pins toward the memory bus (values or enables)
   typedef struct packed {
      logic prog_sel_n;
      logic data_sel_n;
      logic io_sel_n;
      logic rw_n;
      logic wr_rd;
      logic rd_n;
      logic we_n;
      logic bus_cycle_strobe_n_n;
   } embc_pins_t;

endpackage

`default_nettype wire

//--- verification/embc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module embc_mem_model
   import embc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Bus pins seen from the memory side
   input wire embc_pins_t pins_i,
   input wire logic [3:0] stall_i,
   // Ready back to the controller
   output logic ready_o
);
   logic [3:0] cnt_q;

   // Slow device holds ready low for stall_i cycles of each access, then lets go
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cnt_q <= 4'h0;
         ready_o <= 1'h1;
      end
      else if (pins_i.bus_cycle_strobe_n_n === 1'h0 && cnt_q < stall_i)
      begin
         cnt_q <= cnt_q + 4'h1;
         ready_o <= 1'h0;
      end
      else
      begin
         // Pull-up level once the device has released ready
         cnt_q <= (pins_i.bus_cycle_strobe_n_n === 1'h0) ? cnt_q : 4'h0;
         ready_o <= 1'h1;
      end
   end
endmodule

`default_nettype wire

//--- verification/embc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none

module embc_ctrl_bench;
   import embc_pkg::*;
   logic clk_i, rst_b_i, req_i, pd, busy, ack, ill, rdy, emu_n, ifen;
   logic pcs, pcb, pcoe;
   logic [3:0] stall;
   logic [2:0] sync;
   embc_req_t rq;
   embc_ws_t ws_cfg;
   embc_pins_t pins, oe;
   int error_cnt, samples_checked, cyc;

   embc_ctrl dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .req_dat_i(rq),
      .wait_state_config_i(ws_cfg), .power_down_i(pd), .busy_o(busy), .ack_o(ack),
      .illegal_addr_o(ill), .port_c_bit0_sel_i(pcs), .port_c_bit0_i(pcb),
      .port_c_bit0_oe_i(pcoe), .ready_i(rdy), .emulation_output_disable_n_i(emu_n),
      .external_if_enable_i(ifen), .sync_o(sync), .pins_o(pins), .pins_oe_o(oe));

   embc_mem_model mem (.clk_i(clk_i), .rst_b_i(rst_b_i), .pins_i(pins), .stall_i(stall),
      .ready_o(rdy));

   // Free-running 40 MHz clock
   initial
   begin
      clk_i = 1'h0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Hang guard: far more cycles than the whole sequence needs
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One access from a falling edge; strobes checked every cycle until ack
   task automatic acc(input embc_space_t sp, input logic wr, input logic [2:0] w,
      input logic stalled);
      embc_pins_t e;
      int n;
      e.prog_sel_n = (sp != SP_PROG);
      e.data_sel_n = (sp != SP_DATA);
      e.io_sel_n = (sp != SP_IO);
      e.rw_n = !wr;
      e.wr_rd = wr;
      e.rd_n = wr;
      e.we_n = !wr;
      e.bus_cycle_strobe_n_n = 1'h0;
      ws_cfg = '{prog: w, data: w, io: w};
      rq = '{space: sp, write: wr};
      req_i = 1'h1;
      @(negedge clk_i);
      req_i = 1'h0;
      n = 1;
      while (ack !== 1'h1 && n < 40)
      begin
         chk(pins, e);
         chk(busy, 1'h1);
         @(negedge clk_i);
         n++;
      end
      if (stalled)
         chk(8'(n > w + 2), 8'h01);
      else
         chk(8'(n), 8'(w + 2));
      chk(pins, 8'hf7);
   endtask

   task automatic t_spaces();
      logic [2:0] wl [3];
      wl = '{3'h0, 3'h2, 3'h7};
      // Back-to-back accesses over every space and direction, with wait counts 0, 2 and 7
      for (int s = 0; s < 3; s++)
         for (int wr = 0; wr < 2; wr++)
            foreach (wl[i])
               acc(embc_space_t'(s), wr[0], wl[i], 1'h0);
      $display("spaces test done");
   endtask

   task automatic t_ready();
      stall = 4'h4;
      acc(SP_DATA, 1'h0, 3'h4, 1'h1);
      acc(SP_IO, 1'h1, 3'h0, 1'h0);
      stall = 4'h0;
      $display("ready test done");
   endtask

   task automatic t_float();
      // A request made in power down must be refused without any strobe
      pd = 1'h1;
      rq = '{space: SP_PROG, write: 1'h0};
      req_i = 1'h1;
      @(negedge clk_i);
      req_i = 1'h0;
      chk(oe & 8'hf9, 8'h00);
      chk({6'h0, oe.rd_n, oe.we_n}, 8'h03);
      chk(busy, 1'h1);
      chk(pins, 8'hf7);
      @(negedge clk_i);
      chk({ack, ill}, 8'h00);
      pd = 1'h0;
      emu_n = 1'h0;
      repeat (4) @(negedge clk_i);
      chk(oe, 8'h00);
      emu_n = 1'h1;
      repeat (4) @(negedge clk_i);
      chk(oe, 8'hff);
      $display("float test done");
   endtask

   task automatic t_disabled();
      ifen = 1'h0;
      repeat (4) @(negedge clk_i);
      rq = '{space: SP_DATA, write: 1'h1};
      req_i = 1'h1;
      @(negedge clk_i);
      req_i = 1'h0;
      chk(ill, 1'h1);
      chk(pins, 8'hf7);
      @(negedge clk_i);
      chk(ill, 1'h0);
      ifen = 1'h1;
      repeat (4) @(negedge clk_i);
      $display("disabled test done");
   endtask

   task automatic t_port();
      // Shared pin as port bit: level and enable follow the port inputs
      pcs = 1'h1;
      pcb = 1'h1;
      pcoe = 1'h0;
      @(negedge clk_i);
      chk({pins.wr_rd, oe.wr_rd}, 8'h02);
      pcoe = 1'h1;
      @(negedge clk_i);
      chk({pins.wr_rd, oe.wr_rd}, 8'h03);
      pcs = 1'h0;
      @(negedge clk_i);
      chk({pins.wr_rd, oe.wr_rd}, 8'h01);
      acc(SP_DATA, 1'h1, 3'h1, 1'h0);
      $display("port test done");
   endtask

   task automatic t_reset();
      // Reset in mid-access floats the pins at once and drops the access
      ws_cfg = '{prog: 3'h7, data: 3'h7, io: 3'h7};
      rq = '{space: SP_PROG, write: 1'h1};
      req_i = 1'h1;
      @(negedge clk_i);
      req_i = 1'h0;
      @(negedge clk_i);
      chk(pins.bus_cycle_strobe_n_n, 1'h0);
      rst_b_i = 1'h0;
      repeat (2) @(negedge clk_i);
      chk(oe, 8'h00);
      chk(pins, 8'hf7);
      chk({5'h0, sync}, 8'h01);
      rst_b_i = 1'h1;
      @(negedge clk_i);
      chk(oe, 8'h00);
      repeat (3) @(negedge clk_i);
      chk(oe, 8'hff);
      chk({busy, ack, ill}, 8'h00);
      $display("reset test done");
   endtask

   initial
   begin
      rst_b_i = 1'h0;
      req_i = 1'h0;
      pd = 1'h0;
      emu_n = 1'h1;
      ifen = 1'h1;
      stall = 4'h0;
      rq = '{space: SP_PROG, write: 1'h0};
      ws_cfg = '{prog: 3'h0, data: 3'h0, io: 3'h0};
      pcs = 1'h0;
      pcb = 1'h0;
      pcoe = 1'h0;
      repeat (2) @(negedge clk_i);
      chk(oe, 8'h00);
      chk(pins, 8'hf7);
      chk({5'h0, sync}, 8'h01);
      rst_b_i = 1'h1;
      repeat (4) @(negedge clk_i);
      chk({5'h0, sync}, 8'h07);
      t_spaces();
      t_ready();
      t_float();
      t_disabled();
      t_port();
      t_reset();
      end_of_test();
   end
endmodule

`default_nettype wire
